// file: rtl/pho_holdover.sv
// PLL holdover controller: lock detection, lock pin, holdover entry/exit.
// Assumes phase-compare events arrive as one-cycle pulses on clock_i.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Holdover enable bit gates both modes
// - Alignment pin falling edge enters manual holdover
// - Manual exit at next reference compare edge
// - Reset B counter at exit event
// - Low alignment pin stops non-ignoring dividers when enabled in external mode
// - Low lock pin enters automatic holdover
// - Comparator off means lock reads high
// - Automatic holdover holds until reference returns
// - Lock must recharge before re-entry
// - Holdover follows the selected reference
// - Counter code sets lock cycles, 00=5
// - Code 000100b selects current-source lock mode
// - External bit selects pin or automatic
// - Window bit zero selects high range
// - Reference select fields drive buffers, switchover
// - Three frequency monitors flag slow clocks
// - Lock after N good; lose on one bad
// - Charged flag restarts on any false
module pho_holdover
    import pho_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [9:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_we_i,
    output logic [7:0] reg_rdata_o,
    input wire logic phase_compare_event_i,
    input wire logic [7:0] phase_diff_i,
    input wire logic ref_compare_edge_i,
    input wire logic align_pin_n_i,
    input wire logic lock_indicator_pin_i,
    input wire logic primary_reference_edge_i,
    input wire logic secondary_reference_edge_i,
    input wire logic vco_edge_i,
    output logic pump_output_hiz_o,
    output logic b_counter_reset_o,
    output logic [3:0] dist_off_o,
    output logic lock_pin_level_o,
    output logic lock_pin_current_en_o,
    output logic auto_switch_o,
    output logic prefer_secondary_o,
    output logic [1:0] ref_buf_en_o,
    output logic [2:0] freq_low_o
);
    import pho_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0] lock_cfg_reg, lock_cfg_next;
    logic [7:0] pin_ctl_reg, pin_ctl_next;
    logic [7:0] ref_sel_reg, ref_sel_next;
    logic [7:0] ho_cfg_reg, ho_cfg_next;
    logic [7:0] mon_cfg_reg, mon_cfg_next;
    logic [3:0] ignore_reg, ignore_next;
    logic [7:0] rdata_reg, rdata_next;
    logic digital_lock_flag_reg;
    logic charged_lock_flag_reg;
    logic pump_hiz;

    always_comb begin
        lock_cfg_next = lock_cfg_reg;
        pin_ctl_next = pin_ctl_reg;
        ref_sel_next = ref_sel_reg;
        ho_cfg_next = ho_cfg_reg;
        mon_cfg_next = mon_cfg_reg;
        ignore_next = ignore_reg;
        rdata_next = 8'h00;
        if (reg_we_i) begin
            unique case (reg_addr_i)
                PHO_LOCK_DETECT_CONFIG: lock_cfg_next = reg_wdata_i;
                PHO_LOCK_PIN_CONTROL: pin_ctl_next = reg_wdata_i;
                PHO_REFERENCE_SELECT_CONFIG: ref_sel_next = reg_wdata_i;
                PHO_HOLDOVER_CONFIG: ho_cfg_next = reg_wdata_i;
                PHO_FREQ_MONITOR: mon_cfg_next = reg_wdata_i;
                PHO_CHAN_DIV0_CTRL: ignore_next[0] = reg_wdata_i[PHO_IGNORE_ALIGN_BIT];
                PHO_CHAN_DIV1_CTRL: ignore_next[1] = reg_wdata_i[PHO_IGNORE_ALIGN_BIT];
                PHO_CHAN_DIV2_CTRL: ignore_next[2] = reg_wdata_i[PHO_IGNORE_ALIGN_BIT];
                PHO_CHAN_DIV3_CTRL: ignore_next[3] = reg_wdata_i[PHO_IGNORE_ALIGN_BIT];
                default: ;
            endcase
        end
        unique case (reg_addr_i)
            PHO_LOCK_DETECT_CONFIG: rdata_next = lock_cfg_reg;
            PHO_LOCK_PIN_CONTROL: rdata_next = pin_ctl_reg;
            PHO_REFERENCE_SELECT_CONFIG: rdata_next = ref_sel_reg;
            PHO_HOLDOVER_CONFIG: rdata_next = ho_cfg_reg;
            // Status readback merged with the threshold select
            PHO_FREQ_MONITOR: rdata_next = {1'b0, charged_lock_flag_reg, pump_hiz,
                freq_low_o[2], freq_low_o[1], mon_cfg_reg[PHO_MON_EXT_BIT],
                freq_low_o[0], digital_lock_flag_reg};
            PHO_CHAN_DIV0_CTRL: rdata_next = {1'b0, ignore_reg[0], 6'h00};
            PHO_CHAN_DIV1_CTRL: rdata_next = {1'b0, ignore_reg[1], 6'h00};
            PHO_CHAN_DIV2_CTRL: rdata_next = {1'b0, ignore_reg[2], 6'h00};
            PHO_CHAN_DIV3_CTRL: rdata_next = {1'b0, ignore_reg[3], 6'h00};
            default: rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            lock_cfg_reg <= PHO_REG_RESET;
            pin_ctl_reg <= PHO_REG_RESET;
            ref_sel_reg <= PHO_REG_RESET;
            ho_cfg_reg <= PHO_REG_RESET;
            mon_cfg_reg <= PHO_REG_RESET;
            ignore_reg <= 4'h0;
            rdata_reg <= 8'h00;
        end else begin
            lock_cfg_reg <= lock_cfg_next;
            pin_ctl_reg <= pin_ctl_next;
            ref_sel_reg <= ref_sel_next;
            ho_cfg_reg <= ho_cfg_next;
            mon_cfg_reg <= mon_cfg_next;
            ignore_reg <= ignore_next;
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata_o = rdata_reg;
    assign auto_switch_o = ref_sel_reg[PHO_REF_AUTO_SW_BIT];
    assign prefer_secondary_o = ref_sel_reg[PHO_REF_PREFER_BIT];
    assign ref_buf_en_o = ref_sel_reg[PHO_REF_BUF_LSB +: 2];

    ////////////////////////////////////////////////////////////////////////
    // Digital lock detect
    logic [7:0] lock_need, lock_thr, unlock_thr;
    logic [7:0] good_cnt_reg, good_cnt_next;
    logic digital_lock_flag_next;

    always_comb begin
        unique case (lock_cfg_reg[PHO_LD_CNT_LSB +: 2])
            2'b00: lock_need = PHO_LD_COUNT_00;
            2'b01: lock_need = PHO_LD_COUNT_01;
            2'b10: lock_need = PHO_LD_COUNT_10;
            2'b11: lock_need = PHO_LD_COUNT_11;
        endcase
        // Zero selects the high range window
        lock_thr = lock_cfg_reg[PHO_LD_WINDOW_BIT] ? PHO_LOCK_THR_LOW : PHO_LOCK_THR_HIGH;
        unlock_thr = lock_cfg_reg[PHO_LD_WINDOW_BIT] ? PHO_UNLOCK_THR_LOW
                                                     : PHO_UNLOCK_THR_HIGH;
        good_cnt_next = good_cnt_reg;
        digital_lock_flag_next = digital_lock_flag_reg;
        if (lock_cfg_reg[PHO_DLD_DISABLE_BIT]) begin
            good_cnt_next = 8'h00;
            digital_lock_flag_next = 1'b0;
        end else if (phase_compare_event_i) begin
            if (phase_diff_i > unlock_thr) begin
                good_cnt_next = 8'h00;
                digital_lock_flag_next = 1'b0;
            end else if (phase_diff_i < lock_thr) begin
                if (good_cnt_reg != 8'hFF) begin
                    good_cnt_next = good_cnt_reg + 8'h01;
                end
                if (good_cnt_reg + 8'h01 >= lock_need) begin
                    digital_lock_flag_next = 1'b1;
                end
            end else begin
                // Between thresholds: run broken, flag unchanged
                good_cnt_next = 8'h00;
            end
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            good_cnt_reg <= 8'h00;
            digital_lock_flag_reg <= 1'b0;
        end else begin
            good_cnt_reg <= good_cnt_next;
            digital_lock_flag_reg <= digital_lock_flag_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Lock pin drive and current-source charging
    localparam int CW = $clog2(PHO_CHARGE_CYCLES + 1);
    logic [CW-1:0] charge_cnt_reg, charge_cnt_next;
    logic charged_lock_flag_next;
    logic current_mode;

    assign current_mode = (pin_ctl_reg[5:0] == PHO_PIN_MODE_CURRENT);

    always_comb begin
        charge_cnt_next = charge_cnt_reg;
        charged_lock_flag_next = charged_lock_flag_reg;
        if (!digital_lock_flag_reg || !current_mode) begin
            // Any false discharges at once
            charge_cnt_next = '0;
            charged_lock_flag_next = 1'b0;
        end else if (charge_cnt_reg == CW'(PHO_CHARGE_CYCLES - 1)) begin
            charged_lock_flag_next = 1'b1;
        end else begin
            charge_cnt_next = charge_cnt_reg + CW'(1);
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            charge_cnt_reg <= '0;
            charged_lock_flag_reg <= 1'b0;
        end else begin
            charge_cnt_reg <= charge_cnt_next;
            charged_lock_flag_reg <= charged_lock_flag_next;
        end
    end

    assign lock_pin_level_o = (pin_ctl_reg[5:0] == PHO_PIN_MODE_DLD) && digital_lock_flag_reg;
    assign lock_pin_current_en_o = current_mode && digital_lock_flag_reg;

    ////////////////////////////////////////////////////////////////////////
    // Holdover state machine
    logic align_n_sync, lock_pin_sync;
    pho_sync #(.RESET_VALUE(1'b1)) u_align_sync (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .level_i(align_pin_n_i),
        .level_o(align_n_sync)
    );
    pho_sync #(.RESET_VALUE(1'b0)) u_lock_sync (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .level_i(lock_indicator_pin_i),
        .level_o(lock_pin_sync)
    );

    pho_state_t state_reg, state_next;
    logic align_prev_reg;
    logic armed_reg, armed_next;
    logic b_reset_reg, b_reset_next;
    logic ho_en, ext_mode, sensed_lock, align_fall;

    assign ho_en = ho_cfg_reg[PHO_HO_EN_BIT];
    assign ext_mode = ho_cfg_reg[PHO_HO_EXT_BIT];
    // Comparator off: pin always reads high
    assign sensed_lock = !ho_cfg_reg[PHO_HO_CMP_EN_BIT] || lock_pin_sync;
    assign align_fall = align_prev_reg && !align_n_sync;

    always_comb begin
        state_next = state_reg;
        b_reset_next = 1'b0;
        armed_next = armed_reg;
        // Arm only in normal run: a lock seen during holdover must not count
        if (sensed_lock && state_reg == PHO_RUN) begin
            armed_next = 1'b1;
        end
        if (!ho_en) begin
            state_next = PHO_RUN;
        end else begin
            unique case (state_reg)
                PHO_RUN: begin
                    if (ext_mode && align_fall) begin
                        state_next = PHO_MAN_LOW;
                    end else if (!ext_mode && armed_reg && !sensed_lock) begin
                        state_next = PHO_AUTO;
                        armed_next = 1'b0;
                    end
                end
                PHO_MAN_LOW: begin
                    if (align_n_sync) begin
                        state_next = PHO_WAIT_REF;
                    end
                end
                PHO_WAIT_REF, PHO_AUTO: begin
                    // Event from the selected reference path only
                    if (ref_compare_edge_i) begin
                        state_next = PHO_RUN;
                        b_reset_next = 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= PHO_RUN;
            align_prev_reg <= 1'b1;
            armed_reg <= 1'b0;
            b_reset_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            align_prev_reg <= align_n_sync;
            armed_reg <= armed_next;
            b_reset_reg <= b_reset_next;
        end
    end

    assign pump_hiz = (state_reg != PHO_RUN);
    assign pump_output_hiz_o = pump_hiz;
    // Prescaler untouched: only the B counter restarts
    assign b_counter_reset_o = b_reset_reg;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            dist_off_o[i] = ho_en && ext_mode && !align_n_sync && !ignore_reg[i];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Frequency monitors: count idle cycles since last edge
    logic [2:0] mon_edge;
    assign mon_edge = {vco_edge_i, secondary_reference_edge_i, primary_reference_edge_i};
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_mon
            logic [12:0] idle_reg, idle_next;
            logic low_reg, low_next;
            logic [12:0] limit;
            always_comb begin
                limit = (g < 2 && mon_cfg_reg[PHO_MON_EXT_BIT]) ? 13'(PHO_MON_EXTENDED_CYC)
                                                               : 13'(PHO_MON_NORMAL_CYC);
                idle_next = idle_reg;
                low_next = low_reg;
                if (mon_edge[g]) begin
                    idle_next = 13'h0000;
                    low_next = 1'b0;
                end else if (idle_reg >= limit) begin
                    low_next = 1'b1;
                end else begin
                    idle_next = idle_reg + 13'h0001;
                end
            end
            always_ff @(posedge clock_i or posedge rst_i) begin
                if (rst_i) begin
                    idle_reg <= 13'h0000;
                    low_reg <= 1'b0;
                end else begin
                    idle_reg <= idle_next;
                    low_reg <= low_next;
                end
            end
            assign freq_low_o[g] = low_reg;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_enable_gates: assert property (@(posedge clock_i) disable iff (rst_i)
        !ho_en |=> !pump_hiz) else $error("holdover active while disabled");
    a_manual_entry: assert property (@(posedge clock_i) disable iff (rst_i)
        (ho_en && ext_mode && align_fall && state_reg == PHO_RUN) |=> pump_hiz)
        else $error("falling edge did not enter holdover");
    a_exit_on_ref: assert property (@(posedge clock_i) disable iff (rst_i)
        (state_reg == PHO_WAIT_REF && ho_en && !ref_compare_edge_i) |=> pump_hiz)
        else $error("left manual holdover without reference edge");
    a_b_reset_pair: assert property (@(posedge clock_i) disable iff (rst_i)
        ($fell(pump_hiz) && $past(ho_en)) |-> b_counter_reset_o)
        else $error("B reset not with exit");
    a_dist_off: assert property (@(posedge clock_i) disable iff (rst_i)
        (ho_en && ext_mode && !align_n_sync && !ignore_reg[0]) |-> dist_off_o[0])
        else $error("divider 0 not stopped");
    a_auto_entry: assert property (@(posedge clock_i) disable iff (rst_i)
        (ho_en && !ext_mode && armed_reg && !sensed_lock && state_reg == PHO_RUN)
        |=> pump_hiz) else $error("lock loss did not enter holdover");
    a_cmp_off: assert property (@(posedge clock_i) disable iff (rst_i)
        (state_reg == PHO_RUN && !ho_cfg_reg[PHO_HO_CMP_EN_BIT] && !ext_mode)
        |=> state_reg != PHO_AUTO) else $error("entered with comparator off");
    a_hold_no_ref: assert property (@(posedge clock_i) disable iff (rst_i)
        (state_reg == PHO_AUTO && ho_en && !ref_compare_edge_i) |=> pump_hiz)
        else $error("left holdover without reference");
    a_no_reenter: assert property (@(posedge clock_i) disable iff (rst_i)
        $fell(pump_hiz) && !sensed_lock |=> !pump_hiz) else $error("re-entered uncharged");
    a_dld_drop: assert property (@(posedge clock_i) disable iff (rst_i)
        (phase_compare_event_i && phase_diff_i > unlock_thr) |=> !digital_lock_flag_reg)
        else $error("lock kept past unlock threshold");
    a_charge_restart: assert property (@(posedge clock_i) disable iff (rst_i)
        !digital_lock_flag_reg |=> !charged_lock_flag_reg ##1 !charged_lock_flag_reg[*1])
        else $error("charged flag survived a false");

    c_manual: cover property (@(posedge clock_i) disable iff (rst_i)
        state_reg == PHO_MAN_LOW ##[1:200] b_counter_reset_o);
    c_auto: cover property (@(posedge clock_i) disable iff (rst_i)
        state_reg == PHO_AUTO ##[1:200] b_counter_reset_o);
    c_charged: cover property (@(posedge clock_i) disable iff (rst_i)
        $rose(charged_lock_flag_reg));
    c_mon: cover property (@(posedge clock_i) disable iff (rst_i) $rose(freq_low_o[0]));
endmodule : pho_holdover
`default_nettype wire

// file: rtl/pho_pkg.sv
// Constants for the PLL holdover controller.
// Assumes a single 100 MHz clock and 8-bit registers on a simple register port.
package pho_pkg;

    // Register offsets
    localparam logic [9:0] PHO_LOCK_DETECT_CONFIG = 10'h018;
    localparam logic [9:0] PHO_LOCK_PIN_CONTROL = 10'h01A;
    localparam logic [9:0] PHO_REFERENCE_SELECT_CONFIG = 10'h01C;
    localparam logic [9:0] PHO_HOLDOVER_CONFIG = 10'h01D;
    localparam logic [9:0] PHO_FREQ_MONITOR = 10'h01F;
    localparam logic [9:0] PHO_CHAN_DIV0_CTRL = 10'h191;
    localparam logic [9:0] PHO_CHAN_DIV1_CTRL = 10'h194;
    localparam logic [9:0] PHO_CHAN_DIV2_CTRL = 10'h197;
    localparam logic [9:0] PHO_CHAN_DIV3_CTRL = 10'h19A;

    // Reset values
    localparam logic [7:0] PHO_REG_RESET = 8'h00;

    // Field positions
    localparam int PHO_LD_CNT_LSB = 5;
    localparam int PHO_LD_WINDOW_BIT = 4;
    localparam int PHO_DLD_DISABLE_BIT = 3;
    localparam int PHO_REF_AUTO_SW_BIT = 4;
    localparam int PHO_REF_PREFER_BIT = 3;
    localparam int PHO_REF_BUF_LSB = 1;
    localparam int PHO_HO_CMP_EN_BIT = 3;
    localparam int PHO_HO_EXT_BIT = 1;
    localparam int PHO_HO_EN_BIT = 0;
    localparam int PHO_MON_EXT_BIT = 2;
    localparam int PHO_IGNORE_ALIGN_BIT = 6;

    // Lock pin modes
    localparam logic [5:0] PHO_PIN_MODE_DLD = 6'h00;
    localparam logic [5:0] PHO_PIN_MODE_CURRENT = 6'h04;

    // Consecutive in-window cycles per counter code
    localparam logic [7:0] PHO_LD_COUNT_00 = 8'h05;
    localparam logic [7:0] PHO_LD_COUNT_01 = 8'h10;
    localparam logic [7:0] PHO_LD_COUNT_10 = 8'h40;
    localparam logic [7:0] PHO_LD_COUNT_11 = 8'hFF;

    // Phase difference thresholds, high and low range
    localparam logic [7:0] PHO_LOCK_THR_HIGH = 8'h18;
    localparam logic [7:0] PHO_UNLOCK_THR_HIGH = 8'h28;
    localparam logic [7:0] PHO_LOCK_THR_LOW = 8'h08;
    localparam logic [7:0] PHO_UNLOCK_THR_LOW = 8'h0E;

    // Timing
    localparam int PHO_CLK_MHZ = 100;
    localparam int PHO_CHARGE_TIME_NS = 2000;
    localparam int PHO_CHARGE_CYCLES = (PHO_CHARGE_TIME_NS * PHO_CLK_MHZ + 999) / 1000;
    localparam int PHO_MON_NORMAL_NS = 10000;
    localparam int PHO_MON_EXTENDED_NS = 40000;
    localparam int PHO_MON_NORMAL_CYC = (PHO_MON_NORMAL_NS * PHO_CLK_MHZ) / 1000;
    localparam int PHO_MON_EXTENDED_CYC = (PHO_MON_EXTENDED_NS * PHO_CLK_MHZ) / 1000;

    typedef enum logic [1:0] {
        PHO_RUN,
        PHO_MAN_LOW,
        PHO_WAIT_REF,
        PHO_AUTO
    } pho_state_t;

endpackage : pho_pkg

// file: rtl/pho_sync.sv
// Two-flop level synchroniser.
// Assumes the input may change at any time relative to clock_i.
`timescale 1ns/1ps
`default_nettype none
module pho_sync #(
    parameter logic RESET_VALUE = 1'b0
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic level_i,
    output logic level_o
);
    logic first_reg;
    logic second_reg;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            first_reg <= RESET_VALUE;
            second_reg <= RESET_VALUE;
        end else begin
            first_reg <= level_i;
            second_reg <= first_reg;
        end
    end

    assign level_o = second_reg;
endmodule : pho_sync
`default_nettype wire

// file: verification/pho_ref_model.sv
// Reference side model: phase detector pulses, difference value, monitor edges.
// Assumes clock_i is the block clock; every pulse lasts one cycle.
`timescale 1ns/1ps
`default_nettype none
module pho_ref_model #(
    parameter int PERIOD = 8
) (
    input wire logic clock_i,
    input wire logic ref_on_i,
    input wire logic [7:0] diff_i,
    output logic phase_compare_event_o,
    output logic [7:0] phase_diff_o,
    output logic ref_compare_edge_o
);
    int cnt = 0;
    // A lost reference gives no compares and no stale difference value
    always @(posedge clock_i) begin
        cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
        phase_compare_event_o <= ref_on_i && (cnt == 0);
        ref_compare_edge_o <= ref_on_i && (cnt == 0);
        phase_diff_o <= ref_on_i ? diff_i : ~phase_diff_o;
    end
endmodule : pho_ref_model
`default_nettype wire

// file: verification/tb_pll_holdover_controller.sv
// Self-checking bench for the holdover controller.
// Assumes pho_pkg, pho_holdover and pho_ref_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_pll_holdover_controller;
    import pho_pkg::*;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic [9:0] addr = 10'h000;
    logic [7:0] wdata = 8'h00;
    logic we = 1'b0;
    logic align_n = 1'b1;
    logic lock_pin = 1'b0;
    logic ref_on = 1'b1;
    logic [7:0] diff = 8'h30;
    logic rd_req = 1'b0;
    logic rd_q = 1'b0;
    int b_cnt = 0;
    int b_base = 0;
    logic [15:0] lfsr = 16'hE077;
    logic [7:0] exp_q[$];
    logic ev, cmp, hiz, brst, lvl, cur, asw, pref;
    logic [1:0] buf_en;
    logic [3:0] doff;
    logic [2:0] flow;
    logic [7:0] rdata, pdiff, d;
    logic [9:0] regs[8] = '{PHO_LOCK_DETECT_CONFIG, PHO_LOCK_PIN_CONTROL,
        PHO_REFERENCE_SELECT_CONFIG, PHO_HOLDOVER_CONFIG, PHO_CHAN_DIV0_CTRL,
        PHO_CHAN_DIV1_CTRL, PHO_CHAN_DIV2_CTRL, PHO_CHAN_DIV3_CTRL};
    int errors = 0;
    int samples_checked = 0;

    pho_holdover dut_u (.clock_i(clock_i), .rst_i(rst_i), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_we_i(we), .reg_rdata_o(rdata),
        .phase_compare_event_i(ev), .phase_diff_i(pdiff), .ref_compare_edge_i(cmp),
        .align_pin_n_i(align_n), .lock_indicator_pin_i(lock_pin),
        .primary_reference_edge_i(cmp), .secondary_reference_edge_i(cmp),
        .vco_edge_i(ev), .pump_output_hiz_o(hiz), .b_counter_reset_o(brst),
        .dist_off_o(doff), .lock_pin_level_o(lvl), .lock_pin_current_en_o(cur),
        .auto_switch_o(asw), .prefer_secondary_o(pref), .ref_buf_en_o(buf_en),
        .freq_low_o(flow));
    pho_ref_model model_u (.clock_i(clock_i), .ref_on_i(ref_on), .diff_i(diff),
        .phase_compare_event_o(ev), .phase_diff_o(pdiff), .ref_compare_edge_o(cmp));

    always #5 clock_i = ~clock_i;

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] lfsr_next();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr[7:0];
    endfunction : lfsr_next
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [9:0] a, input logic [7:0] v);
        @(posedge clock_i);
        addr <= a;
        wdata <= v;
        we <= 1'b1;
        @(posedge clock_i);
        we <= 1'b0;
    endtask : wr
    task automatic rd(input logic [9:0] a, input logic [7:0] e);
        @(posedge clock_i);
        addr <= a;
        rd_req <= 1'b1;
        exp_q.push_back(e);
        @(posedge clock_i);
        rd_req <= 1'b0;
    endtask : rd
    task automatic wait_hiz(input logic e, input int n);
        int i;
        for (i = 0; i < n && hiz !== e; i++) begin
            @(posedge clock_i);
            #1;
        end
        chk({7'h00, hiz}, {7'h00, e});
    endtask : wait_hiz
    task automatic hold_hiz(input logic e, input int n);
        repeat (n) begin
            @(posedge clock_i);
            #1;
            chk({7'h00, hiz}, {7'h00, e});
        end
    endtask : hold_hiz
    task automatic wait_ev(input int n);
        repeat (n) @(posedge clock_i iff ev);
    endtask : wait_ev
    task automatic give_verdict();
        if (errors == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : give_verdict

    // Read results arrive one cycle after the address; compare in order
    always @(posedge clock_i) begin
        rd_q <= rd_req;
        if (brst === 1'b1) b_cnt <= b_cnt + 1;
        if (rd_q && exp_q.size() > 0) chk(rdata, exp_q.pop_front());
    end

    initial begin
        #200000;
        errors++;
        give_verdict();
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clock_i);
        rst_i <= 1'b0;
        foreach (regs[i]) rd(regs[i], 8'h00);
        foreach (regs[i]) begin
            d = lfsr_next();
            wr(regs[i], d);
            rd(regs[i], (i >= 4) ? (d & 8'h40) : d);
        end
        wr(10'h2AA, 8'h5A);
        rd(10'h2AA, 8'h00);
        wr(PHO_REFERENCE_SELECT_CONFIG, 8'h16);
        #1 chk({4'h0, asw, pref, buf_en}, 8'h0B);
        chk({5'h00, flow}, 8'h00);
        // Lock detect: five good compares in the high range, single bad drops it
        wr(PHO_LOCK_DETECT_CONFIG, 8'h00);
        wr(PHO_LOCK_PIN_CONTROL, 8'h00);
        wr(PHO_HOLDOVER_CONFIG, 8'h00);
        wait_ev(2);
        diff <= 8'h10;
        wait_ev(4);
        repeat (3) @(posedge clock_i);
        #1 chk({7'h00, lvl}, 8'h00);
        wait_ev(1);
        repeat (3) @(posedge clock_i);
        #1 chk({7'h00, lvl}, 8'h01);
        diff <= 8'h20;
        wr(PHO_LOCK_PIN_CONTROL, 8'h04);
        wait_ev(2);
        #1 chk({6'h00, lvl, cur}, 8'h01);
        diff <= 8'h30;
        wait_ev(1);
        repeat (3) @(posedge clock_i);
        #1 chk({6'h00, lvl, cur}, 8'h00);
        // Manual holdover; a level already low must not enter
        wr(PHO_HOLDOVER_CONFIG, 8'h00);
        foreach (regs[i]) if (i >= 4) wr(regs[i], (i == 4) ? 8'h40 : 8'h00);
        align_n <= 1'b0;
        repeat (4) @(posedge clock_i);
        wr(PHO_HOLDOVER_CONFIG, 8'h03);
        hold_hiz(1'b0, 10);
        align_n <= 1'b1;
        repeat (4) @(posedge clock_i);
        align_n <= 1'b0;
        wait_hiz(1'b1, 4);
        #1 chk({4'h0, doff}, 8'h0E);
        ref_on <= 1'b0;
        b_base = b_cnt;
        align_n <= 1'b1;
        hold_hiz(1'b1, 20);
        ref_on <= 1'b1;
        wait_hiz(1'b0, 12);
        repeat (2) @(posedge clock_i);
        chk(8'(b_cnt - b_base), 8'h01);
        // Automatic holdover: entry on low lock pin, hold without reference
        lock_pin <= 1'b1;
        wr(PHO_HOLDOVER_CONFIG, 8'h09);
        repeat (5) @(posedge clock_i);
        ref_on <= 1'b0;
        lock_pin <= 1'b0;
        wait_hiz(1'b1, 5);
        hold_hiz(1'b1, 20);
        // A lock seen while in holdover must not arm a re-entry
        lock_pin <= 1'b1;
        repeat (4) @(posedge clock_i);
        lock_pin <= 1'b0;
        hold_hiz(1'b1, 4);
        b_base = b_cnt;
        ref_on <= 1'b1;
        wait_hiz(1'b0, 12);
        repeat (2) @(posedge clock_i);
        chk(8'(b_cnt - b_base), 8'h01);
        hold_hiz(1'b0, 20);
        // Comparator off reads the lock pin as high
        lock_pin <= 1'b1;
        wr(PHO_HOLDOVER_CONFIG, 8'h01);
        repeat (5) @(posedge clock_i);
        lock_pin <= 1'b0;
        hold_hiz(1'b0, 10);
        // Clearing the enable leaves holdover without a counter reset
        lock_pin <= 1'b1;
        wr(PHO_HOLDOVER_CONFIG, 8'h09);
        repeat (5) @(posedge clock_i);
        ref_on <= 1'b0;
        lock_pin <= 1'b0;
        wait_hiz(1'b1, 5);
        b_base = b_cnt;
        wr(PHO_HOLDOVER_CONFIG, 8'h08);
        wait_hiz(1'b0, 3);
        chk(8'(b_cnt - b_base), 8'h00);
        // References and feedback stay silent past the normal threshold
        repeat (1010) @(posedge clock_i);
        #1 chk({5'h00, flow}, 8'h07);
        give_verdict();
    end
endmodule : tb_pll_holdover_controller
`default_nettype wire
